// ### core/dma_chan.sv
`timescale 1ns/1ns
`default_nettype none
module dma_chan
   import dma_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Programming
   input  wire chan_cfg_t   cfg,
   input  wire logic        force_set,
   // Requests and completion
   input  wire logic        periph_req,
   input  wire logic        xfer_done,
   // State towards the engine
   output logic             pending,
   output logic [23:0]      ram_addr,
   output logic             pp_sel,
   output logic             rq_collision,
   output logic             block_done
);

   logic [13:0] done_q;
   logic        pp_q;
   logic        req_q;
   logic        force_q;
   logic        last_xfer;

   // RAM address walks from the active buffer start in word steps
   assign ram_addr     = (pp_q ? cfg.sec_addr : cfg.pri_addr) + {9'h000, done_q, 1'b0}; // RULE_14
   assign last_xfer    = (done_q == cfg.count); // RULE_04
   assign pending      = cfg.enable & (force_q | req_q); // RULE_11
   assign rq_collision = cfg.enable & periph_req & (force_q | force_set); // RULE_09
   assign block_done   = cfg.enable & xfer_done & last_xfer;
   assign pp_sel       = pp_q;

   // A forced request is served before a peripheral one; new requests win over clears
   always_ff @(posedge clk) begin
      if (!rst_n || !cfg.enable) begin
         done_q  <= 14'h0000; // RULE_11
         pp_q    <= 1'b0;
         req_q   <= 1'b0;
         force_q <= 1'b0; // RULE_12
      end else begin
         force_q <= force_set | (force_q & ~xfer_done); // RULE_12
         req_q   <= periph_req | (req_q & ~(xfer_done & ~force_q));
         if (xfer_done) begin
            if (last_xfer) begin
               done_q <= 14'h0000; // RULE_04
               pp_q   <= cfg.pingpong & ~pp_q; // RULE_14
            end else begin
               done_q <= done_q + 14'h0001;
            end
         end
      end
   end

   a_force_drop: assert property (@(posedge clk) disable iff (!rst_n)
      (force_q && !cfg.enable) |=> !force_q) else $error("force bit kept while disabled"); // RULE_12
   a_block_wrap: assert property (@(posedge clk) disable iff (!rst_n)
      (cfg.enable && xfer_done && last_xfer) |=> done_q == 14'h0000) else $error("block did not wrap"); // RULE_04
   a_pp_flip: assert property (@(posedge clk) disable iff (!rst_n)
      (cfg.enable && cfg.pingpong && xfer_done && last_xfer && $stable(cfg.enable))
      |=> (pp_q != $past(pp_q)) || !cfg.enable) else $error("buffer did not alternate"); // RULE_14

endmodule : dma_chan
`default_nettype wire

// ### core/dma_channel_address_count_status.sv
// How it works
// RULE_01 - Per channel 16-bit RW secondary start address low half, reset zero.
// RULE_02 - Per channel 16-bit RW peripheral address register, reset zero.
// RULE_03 - Software avoids writing peripheral address or count while channel enabled.
// RULE_04 - 14-bit RW count, reset zero; each block moves count plus one items.
// RULE_05 - Count bits 15 and 14 read zero, writes to them ignored.
// RULE_06 - Last RAM address accessed kept as RO high byte and low word.
// RULE_07 - Upper byte of last address high register reads zero.
// RULE_08 - Per channel RO peripheral write collision flag in bits 3..0.
// RULE_09 - Per channel RO flag for forced and peripheral request colliding.
// RULE_10 - Bits 15..4 of both collision registers read zero.
// RULE_11 - A channel transfers only while enabled, idle otherwise.
// RULE_12 - Manual trigger forces one transfer; cleared on completion or disable.
// RULE_13 - Direction set: RAM to peripheral; cleared: peripheral to RAM.
// RULE_14 - Ping-pong alternates blocks between primary and secondary buffers.
// RULE_15 - Collision flags stay set until device reset; writes cannot clear.
// RULE_16 - Last RAM address updates on each RAM access, holds otherwise.
`timescale 1ns/1ns
`default_nettype none
module dma_channel_address_count_status
   import dma_pkg::*;
(
   // Clock and reset
   input  wire logic                CORE_CLK,
   input  wire logic                RST_B,
   // Register port
   input  wire logic [REG_AW-1:0]   REG_ADDR,
   input  wire logic [DATA_W-1:0]   REG_WDATA,
   input  wire logic                REG_WR,
   input  wire logic                REG_RD,
   output logic      [DATA_W-1:0]   REG_RDATA,
   // Peripheral requests and CPU peripheral writes
   input  wire logic [NUM_CH-1:0]   PERIPH_REQ,
   input  wire logic                CPU_PERIPH_WR,
   input  wire logic [DATA_W-1:0]   CPU_PERIPH_ADDR,
   // System bus
   output bus_req_t                 BUS_REQ,
   input  wire logic [DATA_W-1:0]   BUS_RDATA,
   // Interrupt
   output logic                     IRQ
);

   // Programming registers
   logic [NUM_CH-1:0]  en_q;
   logic [NUM_CH-1:0]  dir_q;
   logic [NUM_CH-1:0]  pp_mode_q;
   logic [7:0]         pri_hi_q [NUM_CH];
   logic [15:0]        pri_lo_q [NUM_CH];
   logic [7:0]         sec_hi_q [NUM_CH];
   logic [15:0]        sec_lo_q [NUM_CH];
   logic [15:0]        pad_q    [NUM_CH];
   logic [13:0]        cnt_q    [NUM_CH];

   // Status registers
   logic [23:0]        last_addr_q;
   logic [3:0]         pwc_q;
   logic [3:0]         rqc_q;
   logic [INT_W-1:0]   int_st_q;
   logic [INT_W-1:0]   int_st_d;
   logic [INT_W-1:0]   int_msk_q;
   logic               irq_q;
   logic [15:0]        rdata_q;
   logic [15:0]        rdata_d;

   // Engine
   xfer_state_t        state_q;
   logic [1:0]         cur_q;
   bus_req_t           bus_q;

   // Channel wiring
   chan_cfg_t          cfg      [NUM_CH];
   logic [23:0]        ram_addr [NUM_CH];
   logic [NUM_CH-1:0]  pending;
   logic [NUM_CH-1:0]  pp_sel;
   logic [NUM_CH-1:0]  rq_coll;
   logic [NUM_CH-1:0]  blk_done;
   logic [NUM_CH-1:0]  force_set;
   logic [NUM_CH-1:0]  xfer_done;
   logic [NUM_CH-1:0]  pwc_evt;

   // Address decode
   wire                is_chan  = ~REG_ADDR[COMMON_BIT];
   wire  [1:0]         ch_idx   = REG_ADDR[4:3];
   wire  [2:0]         sub      = REG_ADDR[2:0];
   wire                wr_chan  = REG_WR & is_chan;
   wire                wr_msk   = REG_WR & (REG_ADDR == OFF_INT_MSK);
   wire                wr_st    = REG_WR & (REG_ADDR == OFF_INT_ST);

   // Arbitration: lowest channel number wins, only enabled channels pend
   wire                any_pend = |pending;
   wire  [1:0]         gnt      = pending[0] ? 2'd0 : pending[1] ? 2'd1 : pending[2] ? 2'd2 : 2'd3; // RULE_11
   wire                start    = (state_q == ST_IDLE) & any_pend;
   wire                cur_dir  = dir_q[cur_q];
   wire                gnt_dir  = dir_q[gnt];

   // Source and destination addresses by direction
   wire  [23:0]        src_addr = gnt_dir ? ram_addr[gnt] : {8'h00, pad_q[gnt]}; // RULE_13
   wire  [23:0]        dst_addr = cur_dir ? {8'h00, pad_q[cur_q]} : ram_addr[cur_q]; // RULE_13
   wire                ram_hit  = (start & gnt_dir) | ((state_q == ST_DAT) & ~cur_dir); // RULE_16

   // Peripheral write collision: CPU writes the same peripheral register as our write
   wire                pwc_hit  = (state_q == ST_WR) & cur_dir & CPU_PERIPH_WR
                                  & (CPU_PERIPH_ADDR == pad_q[cur_q]); // RULE_08

   genvar c;
   generate
      for (c = 0; c < NUM_CH; c++) begin : g_ch
         assign cfg[c]       = '{enable: en_q[c], dir: dir_q[c], pingpong: pp_mode_q[c],
                                 pri_addr: {pri_hi_q[c], pri_lo_q[c]},
                                 sec_addr: {sec_hi_q[c], sec_lo_q[c]},
                                 periph_addr: pad_q[c], count: cnt_q[c]};
         assign force_set[c] = wr_chan & (ch_idx == 2'(c)) & (sub == SUB_FORCE) & REG_WDATA[FORCE_BIT]; // RULE_12
         assign xfer_done[c] = (state_q == ST_WR) & (cur_q == 2'(c));
         assign pwc_evt[c]   = pwc_hit & (cur_q == 2'(c));

         dma_chan u_chan (
            .clk          (CORE_CLK),
            .rst_n        (RST_B),
            .cfg          (cfg[c]),
            .force_set    (force_set[c]),
            .periph_req   (PERIPH_REQ[c]),
            .xfer_done    (xfer_done[c]),
            .pending      (pending[c]),
            .ram_addr     (ram_addr[c]),
            .pp_sel       (pp_sel[c]),
            .rq_collision (rq_coll[c]),
            .block_done   (blk_done[c])
         );
      end
   endgenerate

   // Per-channel read selection
   wire  [15:0]        ch_rdata =
        (sub == SUB_CTRL)   ? {en_q[ch_idx], 1'b0, dir_q[ch_idx], 2'b00, pp_mode_q[ch_idx], 10'h000}
      : (sub == SUB_PRI_HI) ? {8'h00, pri_hi_q[ch_idx]}
      : (sub == SUB_PRI_LO) ? pri_lo_q[ch_idx]
      : (sub == SUB_SEC_HI) ? {8'h00, sec_hi_q[ch_idx]}
      : (sub == SUB_SEC_LO) ? sec_lo_q[ch_idx] // RULE_01
      : (sub == SUB_PAD)    ? pad_q[ch_idx] // RULE_02
      : (sub == SUB_CNT)    ? {2'b00, cnt_q[ch_idx]} // RULE_05
      : 16'h0000;

   // Common read selection; unmapped offsets read zero
   assign rdata_d =
        is_chan                    ? ch_rdata
      : (REG_ADDR == OFF_LAST_HI)  ? {8'h00, last_addr_q[23:16]} // RULE_07
      : (REG_ADDR == OFF_LAST_LO)  ? last_addr_q[15:0] // RULE_06
      : (REG_ADDR == OFF_PWC)      ? {12'h000, pwc_q} // RULE_10
      : (REG_ADDR == OFF_RQC)      ? {12'h000, rqc_q} // RULE_10
      : (REG_ADDR == OFF_INT_ST)   ? {8'h00, int_st_q}
      : (REG_ADDR == OFF_INT_MSK)  ? {8'h00, int_msk_q}
      : (REG_ADDR == OFF_PPS)      ? {12'h000, pp_sel}
      : 16'h0000;

   // Event sets win over a same-cycle write-one clear
   assign int_st_d = (int_st_q & ~(wr_st ? REG_WDATA[INT_W-1:0] : 8'h00)) | {pwc_evt | rq_coll, blk_done};

   // Channel programming registers; force is a pulse, not stored here
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         en_q      <= 4'h0;
         dir_q     <= 4'h0;
         pp_mode_q <= 4'h0;
         for (int i = 0; i < NUM_CH; i++) begin
            pri_hi_q[i] <= 8'h00;
            pri_lo_q[i] <= RST_WORD;
            sec_hi_q[i] <= 8'h00;
            sec_lo_q[i] <= RST_WORD; // RULE_01
            pad_q[i]    <= RST_WORD; // RULE_02
            cnt_q[i]    <= 14'h0000; // RULE_04
         end
      end else if (wr_chan) begin
         if (sub == SUB_CTRL) begin
            en_q[ch_idx]      <= REG_WDATA[CTRL_EN_BIT]; // RULE_11
            dir_q[ch_idx]     <= REG_WDATA[CTRL_DIR_BIT];
            pp_mode_q[ch_idx] <= REG_WDATA[CTRL_PP_BIT];
         end else if (sub == SUB_PRI_HI) begin
            pri_hi_q[ch_idx] <= REG_WDATA[7:0];
         end else if (sub == SUB_PRI_LO) begin
            pri_lo_q[ch_idx] <= REG_WDATA;
         end else if (sub == SUB_SEC_HI) begin
            sec_hi_q[ch_idx] <= REG_WDATA[7:0];
         end else if (sub == SUB_SEC_LO) begin
            sec_lo_q[ch_idx] <= REG_WDATA; // RULE_01
         end else if (sub == SUB_PAD) begin
            pad_q[ch_idx] <= REG_WDATA; // RULE_02
         end else if (sub == SUB_CNT) begin
            cnt_q[ch_idx] <= REG_WDATA[13:0]; // RULE_05
         end
      end
   end

   // Transfer engine: read strobe, data return cycle, write strobe
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         state_q <= ST_IDLE;
         cur_q   <= 2'd0;
         bus_q   <= '0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               bus_q.wr <= 1'b0;
               if (any_pend) begin
                  cur_q      <= gnt;
                  bus_q.addr <= src_addr; // RULE_13
                  bus_q.ram  <= gnt_dir;
                  bus_q.rd   <= 1'b1;
                  state_q    <= ST_RD;
               end
            end
            ST_RD: begin
               bus_q.rd <= 1'b0;
               state_q  <= ST_DAT;
            end
            ST_DAT: begin
               bus_q.addr  <= dst_addr; // RULE_13
               bus_q.ram   <= ~cur_dir;
               bus_q.wr    <= 1'b1;
               bus_q.wdata <= BUS_RDATA;
               state_q     <= ST_WR;
            end
            ST_WR: begin
               bus_q.wr <= 1'b0;
               state_q  <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Status, interrupt and read data; collision flags have no software clear
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         last_addr_q <= 24'h000000; // RULE_06
         pwc_q       <= 4'h0;
         rqc_q       <= 4'h0;
         int_st_q    <= 8'h00;
         int_msk_q   <= 8'h00;
         irq_q       <= 1'b0;
         rdata_q     <= RST_WORD;
      end else begin
         if (ram_hit) begin
            last_addr_q <= start ? src_addr : dst_addr; // RULE_16
         end
         pwc_q     <= pwc_q | pwc_evt; // RULE_15
         rqc_q     <= rqc_q | rq_coll; // RULE_15
         int_st_q  <= int_st_d;
         int_msk_q <= wr_msk ? REG_WDATA[INT_W-1:0] : int_msk_q;
         irq_q     <= |(int_st_q & int_msk_q);
         rdata_q   <= REG_RD ? rdata_d : RST_WORD;
      end
   end

   assign REG_RDATA = rdata_q;
   assign BUS_REQ   = bus_q;
   assign IRQ       = irq_q;

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);

   // Engine steps as named sequences
   sequence s_rd;  state_q == ST_RD  && bus_q.rd && !bus_q.wr; endsequence
   sequence s_dat; state_q == ST_DAT && !bus_q.rd; endsequence
   sequence s_wr;  state_q == ST_WR  && bus_q.wr; endsequence

   // Engine, status and register port checks
   a_xfer_steps: assert property (start |=> s_rd ##1 s_dat ##1 s_wr)
      else $error("transfer sequence broken"); // RULE_11
   a_grant_enabled: assert property (start |-> en_q[gnt])
      else $error("disabled channel granted"); // RULE_11
   a_dir_source: assert property ((start && gnt_dir) |=> bus_q.ram && bus_q.addr == $past(ram_addr[gnt]))
      else $error("RAM not the source with direction set"); // RULE_13
   a_last_track: assert property ((state_q == ST_RD && bus_q.ram) |-> last_addr_q == bus_q.addr)
      else $error("last RAM address not captured"); // RULE_16
   a_last_wr: assert property ((state_q == ST_WR && bus_q.ram) |-> last_addr_q == bus_q.addr) // RULE_06
      else $error("last RAM write address not captured");
   a_last_hold: assert property (!ram_hit |=> $stable(last_addr_q))
      else $error("last RAM address moved without access"); // RULE_16
   a_flags_sticky: assert property (1'b1 |=> ((($past(pwc_q) & ~pwc_q) | ($past(rqc_q) & ~rqc_q)) == 4'h0))
      else $error("collision flag cleared"); // RULE_15
   a_rqc_set: assert property ((rq_coll != 4'h0) |=> (rqc_q & $past(rq_coll)) == $past(rq_coll))
      else $error("request collision not flagged"); // RULE_09
   a_pwc_set: assert property (pwc_hit |=> pwc_q[$past(cur_q)])
      else $error("write collision not flagged"); // RULE_08
   a_cnt_upper: assert property ((REG_RD && is_chan && sub == SUB_CNT) |=> REG_RDATA[15:14] == 2'b00)
      else $error("count upper bits not zero"); // RULE_05
   a_coll_upper: assert property ((REG_RD && (REG_ADDR == OFF_PWC || REG_ADDR == OFF_RQC))
      |=> REG_RDATA[15:4] == 12'h000) else $error("collision upper bits not zero"); // RULE_10
   a_last_hi_upper: assert property ((REG_RD && REG_ADDR == OFF_LAST_HI) |=> REG_RDATA[15:8] == 8'h00)
      else $error("last address high byte not zero"); // RULE_07
   a_sec_readback: assert property ((REG_WR && is_chan && sub == SUB_SEC_LO) ##1 (REG_RD && $stable(REG_ADDR))
      |=> REG_RDATA == $past(REG_WDATA, 2)) else $error("secondary address readback wrong"); // RULE_01
   a_pad_readback: assert property ((REG_WR && is_chan && sub == SUB_PAD) ##1 (REG_RD && $stable(REG_ADDR))
      |=> REG_RDATA == $past(REG_WDATA, 2)) else $error("peripheral address readback wrong"); // RULE_02

endmodule : dma_channel_address_count_status
`default_nettype wire

// ### core/dma_pkg.sv
package dma_pkg;

   // Channel count and widths
   localparam int            NUM_CH      = 4;
   localparam int            DATA_W      = 16;
   localparam int            ADDR_W      = 24;
   localparam int            CNT_W       = 14;
   localparam int            REG_AW      = 6;

   // Per-channel register slots, channel c at byte {0, c, slot}
   localparam logic [2:0]    SUB_CTRL    = 3'h0;
   localparam logic [2:0]    SUB_FORCE   = 3'h1;
   localparam logic [2:0]    SUB_PRI_HI  = 3'h2;
   localparam logic [2:0]    SUB_PRI_LO  = 3'h3;
   localparam logic [2:0]    SUB_SEC_HI  = 3'h4;
   localparam logic [2:0]    SUB_SEC_LO  = 3'h5;
   localparam logic [2:0]    SUB_PAD     = 3'h6;
   localparam logic [2:0]    SUB_CNT     = 3'h7;
   localparam int            COMMON_BIT  = 5;

   // Registers shared by all channels
   localparam logic [5:0]    OFF_LAST_HI = 6'h20;
   localparam logic [5:0]    OFF_LAST_LO = 6'h21;
   localparam logic [5:0]    OFF_PWC     = 6'h22;
   localparam logic [5:0]    OFF_RQC     = 6'h23;
   localparam logic [5:0]    OFF_INT_ST  = 6'h24;
   localparam logic [5:0]    OFF_INT_MSK = 6'h25;
   localparam logic [5:0]    OFF_PPS     = 6'h26;

   // Field positions
   localparam int            CTRL_EN_BIT = 15;
   localparam int            CTRL_DIR_BIT = 14 - 1;
   localparam int            CTRL_PP_BIT = 10;
   localparam int            FORCE_BIT   = 15;
   localparam int            INT_W       = 8;

   // Reset values and address step
   localparam logic [15:0]   RST_WORD    = 16'h0000;
   localparam logic [23:0]   RAM_STEP    = 24'h000002;

   // Per-channel programming seen by the transfer engine
   typedef struct packed {
      logic              enable;
      logic              dir;
      logic              pingpong;
      logic [23:0]       pri_addr;
      logic [23:0]       sec_addr;
      logic [15:0]       periph_addr;
      logic [13:0]       count;
   } chan_cfg_t;

   // System bus request driven by the engine
   typedef struct packed {
      logic [23:0]       addr;
      logic              ram;
      logic              rd;
      logic              wr;
      logic [15:0]       wdata;
   } bus_req_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_RD   = 4'b0010,
      ST_DAT  = 4'b0100,
      ST_WR   = 4'b1000
   } xfer_state_t;

endpackage : dma_pkg

// ### verif/bus_partner.sv
`timescale 1ns/1ns
`default_nettype none
module bus_partner
   import dma_pkg::*;
(
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst_n,
   // Bus from the engine
   input  wire bus_req_t      req,
   output logic [DATA_W-1:0]  rdata
);
   // Read data stand one cycle only, then wander so a late sample is caught
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata <= 16'hC3C3;
      end else if (req.rd) begin
         rdata <= req.addr[15:0] ^ 16'h5A5A;
      end else begin
         rdata <= ~rdata;
      end
   end
endmodule : bus_partner
`default_nettype wire

// ### verif/dma_channel_address_count_status_bench.sv
`timescale 1ns/1ns
`default_nettype none
module dma_channel_address_count_status_bench
   import dma_pkg::*;
   ;
   // Clock, reset and register port
   logic                CORE_CLK;
   logic                RST_B;
   logic [REG_AW-1:0]   REG_ADDR;
   logic [DATA_W-1:0]   REG_WDATA;
   logic                REG_WR;
   logic                REG_RD;
   logic [DATA_W-1:0]   REG_RDATA;
   // Requests, system bus and interrupt
   logic [NUM_CH-1:0]   PERIPH_REQ;
   logic                CPU_PERIPH_WR;
   logic [DATA_W-1:0]   CPU_PERIPH_ADDR;
   bus_req_t            BUS_REQ;
   logic [DATA_W-1:0]   BUS_RDATA;
   logic                IRQ;
   // Tallies and scratch
   int                  failures;
   int                  n_compared;
   logic [DATA_W-1:0]   rd_v;
   bus_req_t            seen;

   // Device and far side
   dma_channel_address_count_status dma_channel_address_count_status_i (
      .CORE_CLK(CORE_CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .PERIPH_REQ(PERIPH_REQ),
      .CPU_PERIPH_WR(CPU_PERIPH_WR), .CPU_PERIPH_ADDR(CPU_PERIPH_ADDR), .BUS_REQ(BUS_REQ),
      .BUS_RDATA(BUS_RDATA), .IRQ(IRQ));
   bus_partner bus_partner_i (.clk(CORE_CLK), .rst_n(RST_B), .req(BUS_REQ), .rdata(BUS_RDATA));

   // Clock
   always #5 CORE_CLK = ~CORE_CLK;

   function automatic logic [5:0] roff(input int c, input logic [2:0] s);
      return {1'b0, c[1:0], s};
   endfunction : roff

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // Register port cycles, one strobe cycle each
   task automatic reg_wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge CORE_CLK);
      REG_WR    <= 1'b1;
      REG_ADDR  <= a;
      REG_WDATA <= d;
      @(posedge CORE_CLK);
      REG_WR    <= 1'b0;
   endtask : reg_wr

   task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp, input string what);
      @(posedge CORE_CLK);
      REG_RD   <= 1'b1;
      REG_ADDR <= a;
      @(posedge CORE_CLK);
      REG_RD   <= 1'b0;
      #1;
      rd_v = REG_RDATA;
      chk(rd_v, exp, what);
   endtask : rd_chk

   // Write then read back at once, so the readback pattern really occurs
   task automatic wr_rd(input logic [5:0] a, input logic [15:0] d, input string what);
      @(posedge CORE_CLK);
      REG_WR    <= 1'b1;
      REG_ADDR  <= a;
      REG_WDATA <= d;
      @(posedge CORE_CLK);
      REG_WR    <= 1'b0;
      REG_RD    <= 1'b1;
      @(posedge CORE_CLK);
      REG_RD    <= 1'b0;
      #1;
      chk(REG_RDATA, d, what);
   endtask : wr_rd

   task automatic pulse(input logic [3:0] m);
      @(posedge CORE_CLK);
      PERIPH_REQ <= m;
      @(posedge CORE_CLK);
      PERIPH_REQ <= '0;
   endtask : pulse

   // Bounded wait for a read or write strobe on the system bus
   task automatic wait_bus(input bit want_wr, output bus_req_t r);
      int k;
      for (k = 0; k < 30; k++) begin
         @(posedge CORE_CLK);
         #1;
         if ((want_wr ? BUS_REQ.wr : BUS_REQ.rd) === 1'b1) break;
      end
      r = BUS_REQ;
      chk(k < 30, 1'b1, "bus strobe missing");
   endtask : wait_bus

   task automatic no_rd(input int n);
      int hits;
      hits = 0;
      repeat (n) begin
         @(posedge CORE_CLK);
         #1;
         if (BUS_REQ.rd !== 1'b0) hits++;
      end
      chk(hits, 0, "unexpected bus read");
   endtask : no_rd

   // One transfer; peripheral side compared on its low 16 bits
   task automatic xfer(input bit dir, input logic [23:0] ram_a, input logic [15:0] pad);
      logic [23:0] src;
      src = dir ? ram_a : {8'h00, pad};
      wait_bus(1'b0, seen);
      chk({seen.ram, dir ? seen.addr : {8'h00, seen.addr[15:0]}}, {dir, src}, "read side");
      wait_bus(1'b1, seen);
      chk({seen.ram, dir ? {8'h00, seen.addr[15:0]} : seen.addr}, {~dir, dir ? {8'h00, pad} : ram_a},
          "write side");
      chk(seen.wdata, src[15:0] ^ 16'h5A5A, "moved data");
   endtask : xfer

   task automatic t_reset();
      for (int c = 0; c < NUM_CH; c++) begin
         rd_chk(roff(c, SUB_SEC_LO), 16'h0000, "secondary low reset");
         rd_chk(roff(c, SUB_PAD), 16'h0000, "peripheral address reset");
         rd_chk(roff(c, SUB_CNT), 16'h0000, "count reset");
      end
      rd_chk(OFF_LAST_HI, 16'h0000, "last high reset");
      rd_chk(OFF_LAST_LO, 16'h0000, "last low reset");
      rd_chk(OFF_PWC, 16'h0000, "write collision reset");
      rd_chk(OFF_RQC, 16'h0000, "request collision reset");
   endtask : t_reset

   // Read-write, unimplemented bits, read-only and unmapped places
   task automatic t_regs();
      wr_rd(roff(3, SUB_SEC_LO), 16'hA5C3, "secondary low");
      wr_rd(roff(3, SUB_PAD), 16'h5A3C, "peripheral address");
      reg_wr(roff(3, SUB_CNT), 16'hFFFF);
      reg_wr(OFF_LAST_LO, 16'hFFFF);
      reg_wr(6'h3F, 16'hFFFF);
      rd_chk(roff(3, SUB_CNT), 16'h3FFF, "count top bits");
      rd_chk(OFF_LAST_LO, 16'h0000, "last low not writable");
      rd_chk(6'h3F, 16'h0000, "unmapped");
   endtask : t_regs

   // Two blocks of count+1 transfers, alternating buffers, then the interrupt
   task automatic t_pingpong();
      logic [23:0] a;
      reg_wr(roff(0, SUB_PRI_HI), 16'h0001);
      reg_wr(roff(0, SUB_PRI_LO), 16'h1000);
      reg_wr(roff(0, SUB_SEC_HI), 16'h0002);
      reg_wr(roff(0, SUB_SEC_LO), 16'h2000);
      reg_wr(roff(0, SUB_PAD), 16'h1234);
      reg_wr(roff(0, SUB_CNT), 16'h0001);
      reg_wr(roff(0, SUB_CTRL), 16'h8400);
      for (int i = 0; i < 4; i++) begin
         a = (i < 2) ? 24'h011000 + 24'(2 * i) : 24'h022000 + 24'(2 * (i - 2));
         pulse(4'h1);
         xfer(1'b0, a, 16'h1234);
         if (i == 1) rd_chk(OFF_PPS, 16'h0001, "secondary selected");
      end
      rd_chk(OFF_PPS, 16'h0000, "primary selected again");
      rd_chk(OFF_LAST_HI, 16'h0002, "last high");
      rd_chk(OFF_LAST_LO, 16'h2002, "last low");
      chk(IRQ, 1'b0, "masked interrupt");
      reg_wr(OFF_INT_MSK, 16'h0001);
      repeat (2) @(posedge CORE_CLK);
      #1;
      chk(IRQ, 1'b1, "unmasked interrupt");
      reg_wr(OFF_INT_ST, 16'h0001);
      repeat (2) @(posedge CORE_CLK);
      #1;
      chk(IRQ, 1'b0, "cleared interrupt");
      reg_wr(roff(0, SUB_CTRL), 16'h0000);
      pulse(4'h1);
      no_rd(12);
   endtask : t_pingpong

   // Forced RAM-to-peripheral transfer while the CPU writes the same register
   task automatic t_force();
      reg_wr(roff(1, SUB_PAD), 16'h00F0);
      reg_wr(roff(1, SUB_PRI_LO), 16'h0800);
      reg_wr(roff(1, SUB_CTRL), 16'hA000);
      CPU_PERIPH_ADDR <= 16'h00F0;
      CPU_PERIPH_WR   <= 1'b1;
      reg_wr(roff(1, SUB_FORCE), 16'h8000);
      xfer(1'b1, 24'h000800, 16'h00F0);
      // CPU write must still stand in the cycle the bus write strobe stands
      @(posedge CORE_CLK);
      CPU_PERIPH_WR <= 1'b0;
      no_rd(12);
      rd_chk(OFF_PWC, 16'h0002, "write collision");
      rd_chk(OFF_LAST_LO, 16'h0800, "last low on RAM read");
      reg_wr(roff(1, SUB_CTRL), 16'h0000);
   endtask : t_force

   // Forced and peripheral requests in one cycle; flags survive writes
   task automatic t_collide();
      reg_wr(roff(2, SUB_CTRL), 16'h8000);
      @(posedge CORE_CLK);
      REG_WR     <= 1'b1;
      REG_ADDR   <= roff(2, SUB_FORCE);
      REG_WDATA  <= 16'h8000;
      PERIPH_REQ <= 4'h4;
      @(posedge CORE_CLK);
      REG_WR     <= 1'b0;
      PERIPH_REQ <= '0;
      repeat (30) @(posedge CORE_CLK);
      rd_chk(OFF_RQC, 16'h0004, "request collision");
      reg_wr(OFF_RQC, 16'hFFFF);
      reg_wr(OFF_PWC, 16'hFFFF);
      rd_chk(OFF_RQC, 16'h0004, "request flag kept");
      rd_chk(OFF_PWC, 16'h0002, "write flag kept, top zero");
      reg_wr(roff(2, SUB_CTRL), 16'h0000);
      pulse(4'h8);
      no_rd(12);
   endtask : t_collide

   // Only a reset clears the collision flags
   task automatic t_rereset();
      @(posedge CORE_CLK);
      RST_B <= 1'b0;
      repeat (6) @(posedge CORE_CLK);
      RST_B <= 1'b1;
      @(posedge CORE_CLK);
      rd_chk(OFF_PWC, 16'h0000, "write flag after reset");
      rd_chk(OFF_RQC, 16'h0000, "request flag after reset");
      rd_chk(roff(3, SUB_CNT), 16'h0000, "count after reset");
   endtask : t_rereset

   task automatic end_sim();
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim

   // Main sequence
   initial begin
      CORE_CLK        = 1'b0;
      RST_B           = 1'b0;
      REG_ADDR        = '0;
      REG_WDATA       = '0;
      REG_WR          = 1'b0;
      REG_RD          = 1'b0;
      PERIPH_REQ      = '0;
      CPU_PERIPH_WR   = 1'b0;
      CPU_PERIPH_ADDR = '0;
      failures        = 0;
      n_compared      = 0;
      repeat (6) @(posedge CORE_CLK);
      RST_B <= 1'b1;
      @(posedge CORE_CLK);
      t_reset();
      t_regs();
      t_pingpong();
      t_force();
      t_collide();
      t_rereset();
      end_sim();
   end

   // Watchdog, far beyond the few hundred cycles the run needs
   initial begin
      #100000;
      failures++;
      end_sim();
   end
endmodule : dma_channel_address_count_status_bench
`default_nettype wire
